//--- hw/table_access_pkg.sv
// package: constants and types for program-space table access
package table_access_pkg;
  localparam int PWORD_W = 24;
  localparam int DWORD_W = 16;
  localparam int PAGE_W = 8;
  localparam int EA_W = 16;
  localparam int PADDR_W = 24;
  localparam int CFG_BIT = 7;
  localparam int LOW_HI = 15;
  localparam int HIGH_LO = 16;
  localparam int HIGH_HI = 23;
  localparam int BYTE_W = 8;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
  localparam logic [DWORD_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [PADDR_W-1:0] ADDR_RESET = 24'h00_0000;

  typedef enum logic [3:0] {
    OP_READ_LOW   = 4'b0001,
    OP_WRITE_LOW  = 4'b0010,
    OP_READ_HIGH  = 4'b0100,
    OP_WRITE_HIGH = 4'b1000
  } table_op_type;
endpackage

//--- hw/table_read_mux.sv
// read data steering for low and high table reads
module table_read_mux (
  input wire logic [23:0] i_pword,
  input wire logic i_high,
  input wire logic i_byte_mode,
  input wire logic i_byte_sel,
  output logic [15:0] o_data
);
  always_comb begin
    o_data = table_access_pkg::DATA_RESET;
    if (!i_high) begin
      if (!i_byte_mode) begin
        o_data = i_pword[table_access_pkg::LOW_HI:0];
      end else if (i_byte_sel) begin
        o_data[7:0] = i_pword[15:8];
      end else begin
        o_data[7:0] = i_pword[7:0];
      end
    end else begin
      // upper byte only through this path; phantom byte stays zero
      if (!i_byte_mode) begin
        o_data[7:0] = i_pword[table_access_pkg::HIGH_HI:
                              table_access_pkg::HIGH_LO];
      end else if (!i_byte_sel) begin
        o_data[7:0] = i_pword[23:16];
      end
    end
  end
endmodule

//--- hw/table_access.sv
// top: table instruction datapath between core and program memory
module table_access (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_page_we,
  input wire logic [7:0] i_page_wdata,
  input wire logic i_op_valid,
  input wire logic [3:0] i_op,
  input wire logic i_byte_mode,
  input wire logic [15:0] i_ea,
  input wire logic [15:0] i_wdata,
  input wire logic [23:0] i_pm_rdata,
  output logic [7:0] o_page,
  output logic [23:0] o_pm_addr,
  output logic o_pm_rd,
  output logic o_pm_we,
  output logic [23:0] o_pm_wmask,
  output logic [23:0] o_pm_wdata,
  output logic o_cfg_space,
  output logic o_wr_blocked,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  // ************************************************************
  // page register and request stage
  // ************************************************************
  logic [7:0] page_q, page_d;
  logic [23:0] addr_q, addr_d;
  logic rd_q, rd_d, high_q, high_d, bmode_q, bmode_d, bsel_q, bsel_d;
  logic we_q, we_d, blk_q, blk_d, cfg_q, cfg_d;
  logic [23:0] wmask_q, wmask_d, wdat_q, wdat_d;
  logic rv_q, rv_d;
  logic [15:0] rdat_q, rdat_d;
  logic [15:0] mux_data;
  logic is_wr, is_cfg;
  logic [7:0] wbyte;

  // page load; an op on the same edge still sees the old page
  always_comb begin
    page_d = page_q;
    if (i_page_we) begin
      page_d = i_page_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_q <= table_access_pkg::PAGE_RESET;
    end else begin
      page_q <= page_d;
    end
  end

  // ************************************************************
  // request decode and program memory strobes
  // ************************************************************
  // writes are judged on the page that stands at the request edge,
  // so a page change and a write in one cycle cannot slip through
  always_comb begin
    is_cfg = page_q[table_access_pkg::CFG_BIT];
    is_wr = (i_op == table_access_pkg::OP_WRITE_LOW) ||
            (i_op == table_access_pkg::OP_WRITE_HIGH);
    addr_d = addr_q;
    rd_d = 1'b0;
    we_d = 1'b0;
    blk_d = 1'b0;
    cfg_d = cfg_q;
    high_d = high_q;
    bmode_d = bmode_q;
    bsel_d = bsel_q;
    wmask_d = wmask_q;
    wdat_d = wdat_q;
    // byte writes place the low data byte at the selected lane
    wbyte = i_wdata[7:0];
    if (i_op_valid) begin
      addr_d = {page_q, i_ea};
      cfg_d = is_cfg;
      bmode_d = i_byte_mode;
      bsel_d = i_ea[0];
      high_d = (i_op == table_access_pkg::OP_READ_HIGH) ||
               (i_op == table_access_pkg::OP_WRITE_HIGH);
      rd_d = !is_wr;
      we_d = is_wr && !is_cfg;
      blk_d = is_wr && is_cfg;
      wmask_d = 24'h00_0000;
      wdat_d = 24'h00_0000;
      case (i_op)
        table_access_pkg::OP_WRITE_LOW: begin
          if (!i_byte_mode) begin
            wmask_d[15:0] = 16'hFFFF;
            wdat_d[15:0] = i_wdata;
          end else if (i_ea[0]) begin
            wmask_d[15:8] = 8'hFF;
            wdat_d[15:8] = wbyte;
          end else begin
            wmask_d[7:0] = 8'hFF;
            wdat_d[7:0] = wbyte;
          end
        end
        table_access_pkg::OP_WRITE_HIGH: begin
          // phantom byte writes go nowhere
          if (!i_byte_mode || !i_ea[0]) begin
            wmask_d[23:16] = 8'hFF;
            wdat_d[23:16] = wbyte;
          end
        end
        table_access_pkg::OP_READ_LOW: begin
          rd_d = 1'b1;
        end
        table_access_pkg::OP_READ_HIGH: begin
          rd_d = 1'b1;
        end
        default: begin
          rd_d = 1'b0;
          we_d = 1'b0;
          blk_d = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // read return: memory answers in the same cycle as o_pm_rd
  // ************************************************************
  table_read_mux u_mux (
    .i_pword(i_pm_rdata),
    .i_high(high_q),
    .i_byte_mode(bmode_q),
    .i_byte_sel(bsel_q),
    .o_data(mux_data)
  );

  // ************************************************************
  // request registers
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= table_access_pkg::ADDR_RESET;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      blk_q <= 1'b0;
      cfg_q <= 1'b0;
      high_q <= 1'b0;
      bmode_q <= 1'b0;
      bsel_q <= 1'b0;
      wmask_q <= table_access_pkg::ADDR_RESET;
      wdat_q <= table_access_pkg::ADDR_RESET;
    end else begin
      addr_q <= addr_d;
      rd_q <= rd_d;
      we_q <= we_d;
      blk_q <= blk_d;
      cfg_q <= cfg_d;
      high_q <= high_d;
      bmode_q <= bmode_d;
      bsel_q <= bsel_d;
      wmask_q <= wmask_d;
      wdat_q <= wdat_d;
    end
  end

  // ************************************************************
  // read result capture
  // ************************************************************
  // result is held until the next read so the core may take it late
  always_comb begin
    rv_d = rd_q;
    rdat_d = rdat_q;
    if (rd_q) begin
      rdat_d = mux_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rv_q <= 1'b0;
      rdat_q <= table_access_pkg::DATA_RESET;
    end else begin
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  // ************************************************************
  // outputs, each straight from its register
  // ************************************************************
  assign o_page = page_q;
  assign o_pm_addr = addr_q;
  assign o_pm_rd = rd_q;
  assign o_pm_we = we_q;
  assign o_pm_wmask = wmask_q;
  assign o_pm_wdata = wdat_q;
  assign o_cfg_space = cfg_q;
  assign o_wr_blocked = blk_q;
  assign o_rd_valid = rv_q;
  assign o_rd_data = rdat_q;
endmodule

//--- tb/table_access_assertions.sv
// checker: port-level properties of the table access block
module table_access_assertions (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_op_valid,
  input wire logic [3:0] i_op,
  input wire logic i_byte_mode,
  input wire logic [15:0] i_ea,
  input wire logic [23:0] i_pm_rdata,
  input wire logic [7:0] o_page,
  input wire logic [23:0] o_pm_addr,
  input wire logic o_pm_we,
  input wire logic o_cfg_space,
  input wire logic o_wr_blocked,
  input wire logic [15:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic rl, rh, wr;
  assign rl = i_op_valid && i_op == 4'h1;
  assign rh = i_op_valid && i_op == 4'h4;
  assign wr = i_op_valid && (i_op == 4'h2 || i_op == 4'h8);
  a_addr_form: assert property ((rl || rh) |=>
    o_pm_addr == {$past(o_page), $past(i_ea)}) else $error("bad addr");
  a_cfg_flag: assert property ((rl || rh) |=>
    o_cfg_space == $past(o_page[7])) else $error("bad cfg flag");
  a_cfg_nowrite: assert property (wr && o_page[7] |=>
    o_wr_blocked && !o_pm_we) else $error("cfg write taken");
  a_user_write: assert property (wr && !o_page[7] |=>
    o_pm_we && !o_wr_blocked) else $error("user write lost");
  a_word_low: assert property (rl && !i_byte_mode ##1 1 |=>
    o_rd_data == $past(i_pm_rdata[15:0])) else $error("bad low word");
  a_byte_low: assert property (rl && i_byte_mode ##1 1 |=>
    o_rd_data == {8'h00, $past(i_ea[0], 2) ? $past(i_pm_rdata[15:8])
    : $past(i_pm_rdata[7:0])}) else $error("bad low byte");
  a_word_high: assert property (rh && !i_byte_mode ##1 1 |=>
    o_rd_data == {8'h00, $past(i_pm_rdata[23:16])}) else $error("bad high");
  a_phantom_zero: assert property (rh && i_byte_mode && i_ea[0] ##1 1 |=>
    o_rd_data == 16'h0000) else $error("phantom not zero");
endmodule
bind table_access table_access_assertions table_access_assertions_i (.*);

//--- tb/prog_mem_model.sv
// program memory model: answers reads, scrambles when idle
module prog_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_rd,
  input wire logic [23:0] i_addr,
  output logic [23:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] junk_q = 24'h0F_0F0F;
  always @(posedge i_sys_clk) junk_q <= ~junk_q;
  // idle bus toggles so stale data never looks valid
  assign o_rdata = i_rd ? i_addr ^ 24'h5A_3C96 : junk_q;
endmodule

//--- tb/tb_table_access.sv
// testbench: table access block against a program memory model
module tb_table_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_page_we = 1'b0;
  logic i_op_valid = 1'b0, i_byte_mode = 1'b0;
  logic [7:0] i_page_wdata = 8'h00, o_page, cur_page = 8'h00;
  logic [3:0] i_op = 4'h0;
  logic [15:0] i_ea = 16'h0000, i_wdata = 16'hA55A, o_rd_data;
  logic [23:0] i_pm_rdata, o_pm_addr, o_pm_wmask, o_pm_wdata;
  logic o_pm_rd, o_pm_we, o_cfg_space, o_wr_blocked, o_rd_valid;
  int num_errors = 0, check_count = 0;
  table_access table_access_i (.*);
  prog_mem_model prog_mem_model_i (.i_sys_clk(i_sys_clk), .i_rd(o_pm_rd),
    .i_addr(o_pm_addr), .o_rdata(i_pm_rdata));
  initial forever #2 i_sys_clk = ~i_sys_clk;
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge i_sys_clk);
    #1;
  endtask
  task set_page(input logic [7:0] p);
    tick;
    {i_page_we, i_page_wdata} = {1'b1, p};
    tick;
    i_page_we = 1'b0;
    cur_page = p;
    chk(o_page, cur_page);
  endtask
  task op(input logic [3:0] c, input logic bm, input logic [15:0] ea);
    tick;
    {i_op_valid, i_op, i_byte_mode, i_ea} = {1'b1, c, bm, ea};
    tick;
    i_op_valid = 1'b0;
    chk(o_pm_addr, {cur_page, ea});
  endtask
  task test_reads;
    logic [23:0] r;
    logic [15:0] ea, e;
    for (int i = 0; i < 6; i++) begin
      ea = 16'h1234 + 16'(i);
      r = {cur_page, ea} ^ 24'h5A_3C96;
      op(i < 3 ? 4'h1 : 4'h4, i % 3 != 0, ea);
      chk(o_pm_rd, 1'b1);
      if (i < 3)
        e = i == 0 ? r[15:0] : {8'h00, ea[0] ? r[15:8] : r[7:0]};
      else
        e = i == 5 ? 16'h0000 : {8'h00, r[23:16]};
      tick;
      chk(o_rd_valid, 1'b1);
      chk(o_rd_data, e);
    end
    $display("reads done, page %h", o_page);
  endtask
  task test_writes(input logic cfg);
    logic [23:0] m, d;
    for (int i = 0; i < 4; i++) begin
      op(i % 2 == 0 ? 4'h2 : 4'h8, i > 1, i > 1 ? 16'h0101 : 16'h0100);
      m = i == 0 ? 24'h00_FFFF : i == 1 ? 24'hFF_0000 :
          i == 2 ? 24'h00_FF00 : 24'h00_0000;
      d = i == 0 ? 24'h00_A55A : i == 1 ? 24'h5A_0000 :
          i == 2 ? 24'h00_5A00 : 24'h00_0000;
      chk(o_pm_rd, 1'b0);
      chk(o_pm_we, !cfg);
      chk(o_wr_blocked, cfg);
      chk(o_cfg_space, cfg);
      if (!cfg) begin
        chk(o_pm_wmask, m);
        chk(o_pm_wdata & o_pm_wmask, d);
      end
    end
    $display("writes done, cfg %b", cfg);
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_arst_n = 1'b1;
    set_page(8'h12);
    test_reads;
    test_writes(1'b0);
    set_page(8'h80);
    test_reads;
    test_writes(1'b1);
    test_done;
  end
  initial begin
    #20000;
    num_errors++;
    test_done;
  end
endmodule
